// file: common/pcc_pkg.sv
// shared constants and types of the parameter channel codec
package pcc_pkg;

	// request codes
	localparam logic [3:0] PCC_REQ_NONE      = 4'h0;
	localparam logic [3:0] PCC_REQ_READ_ARR  = 4'h6;
	localparam logic [3:0] PCC_REQ_WRITE_ARR = 4'h7;
	// response codes
	localparam logic [3:0] PCC_RSP_NONE      = 4'h0;
	localparam logic [3:0] PCC_RSP_WORD      = 4'h4;
	localparam logic [3:0] PCC_RSP_ERROR     = 4'h7;
	// error numbers
	localparam logic [15:0] PCC_ERR_NO_PARAM = 16'h0000;
	localparam logic [15:0] PCC_ERR_NO_REQ   = 16'h006A;

	// field positions of word 1
	localparam int PCC_CODE_LSB = 12;
	localparam int PCC_PNU_MSB  = 10;
	// field positions of word 2
	localparam int PCC_SUB_LSB  = 8;
	localparam int PCC_PAGE_MSB = 7;
	// field positions of a connector in word 4
	localparam int PCC_DO_LSB   = 10;
	localparam int PCC_CIDX_MSB = 9;

	localparam logic [7:0]  PCC_PAGE_0    = 8'h00;
	localparam logic [7:0]  PCC_PAGE_6000 = 8'h90;
	localparam logic [15:0] PCC_OFS_6000  = 16'h1770;
	localparam logic [5:0]  PCC_DRIVE_OBJ = 6'h3F;

	// parameter store window: full numbers 6000 to 6000+depth-1 or 0..depth-1
	localparam int PCC_STORE_DEPTH = 16;
	localparam int PCC_STORE_AW    = 4;
	localparam logic [15:0] PCC_STORE_BASE0 = 16'h0000;
	localparam logic [31:0] PCC_STORE_RESET = 32'h0000_0000;

	// telegram selection
	localparam logic [15:0] PCC_TEL_FREE    = 16'h03E7;
	localparam logic [15:0] PCC_TEL_RESET   = 16'h0001;
	localparam int          PCC_MAP_WORDS   = 8;
	localparam int          PCC_LOCKED_WORDS = 2;
	localparam logic [3:0]  PCC_LOCKED_RESET = 4'h2;

	// local register port
	localparam logic [3:0] PCC_ADDR_TEL     = 4'h0;
	localparam logic [3:0] PCC_ADDR_TEL_EXT = 4'h1;
	localparam logic [3:0] PCC_ADDR_STATUS  = 4'h2;
	localparam logic [3:0] PCC_ADDR_MAPLOCK = 4'h3;

	typedef struct packed {
		logic [15:0] param_id_word;
		logic [15:0] index_word;
		logic [15:0] value_high_word;
		logic [15:0] value_low_word;
	} pcc_chan_t;

	typedef enum logic [2:0] {
		PCC_ST_IDLE = 3'b001,
		PCC_ST_EXEC = 3'b010,
		PCC_ST_RESP = 3'b100
	} pcc_state_t;

endpackage

// file: sim/pcc_master.sv
// fieldbus master model offering one parameter request at a time
`timescale 1ns/1ps
`default_nettype none
module pcc_master
(
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_go,
	input  wire pcc_pkg::pcc_chan_t i_req,
	input  wire logic               i_ready,
	output logic                    o_valid,
	output pcc_pkg::pcc_chan_t      o_req
);
	import pcc_pkg::*;
	pcc_chan_t req_q;
	logic      valid_q;
	wire logic is_rd = i_req.param_id_word[15:12] == PCC_REQ_READ_ARR;
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			valid_q <= 1'b0;
			req_q   <= '0;
		end
		else if (valid_q && i_ready)
			valid_q <= 1'b0;
		else if (i_go)
		begin
			valid_q <= 1'b1;
			req_q   <= is_rd ? {i_req[63:32], 32'h0000_0000} : i_req;
		end
	end
	// released words show garbage so a stale request cannot pass
	assign o_valid = valid_q;
	assign o_req   = valid_q ? req_q : ~req_q;
endmodule
`default_nettype wire

// file: sim/pcc_props.sv
// port assertions of the parameter channel codec
`timescale 1ns/1ps
`default_nettype none
module pcc_props
(
	input wire logic               I_CLK_SYS,
	input wire logic               I_RST,
	input wire logic               I_REQ_VALID,
	input wire pcc_pkg::pcc_chan_t I_REQ,
	input wire logic               O_REQ_READY,
	input wire logic               O_RSP_VALID,
	input wire pcc_pkg::pcc_chan_t O_RSP,
	input wire logic [3:0]         I_REG_ADDR,
	input wire logic [15:0]        I_REG_WDATA,
	input wire logic               I_REG_WR,
	input wire logic               I_REG_RD,
	input wire logic [15:0]        O_REG_RDATA,
	input wire logic [7:0]         O_MAP_LOCKED,
	input wire logic               O_CONN_VALID,
	input wire logic [15:0]        O_CONN_NUMBER,
	input wire logic [9:0]         O_CONN_INDEX
);
	import pcc_pkg::*;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);
	wire logic        take = I_REQ_VALID && O_REQ_READY;
	wire logic [3:0]  code = I_REQ.param_id_word[15:12];
	wire logic [11:0] num  = I_REQ.param_id_word[11:0];
	wire logic [15:0] idx  = I_REQ.index_word;
	wire logic        err  = O_RSP_VALID && O_RSP.param_id_word[15:12] == 4'h7;
	wire logic [15:0] eno  = O_RSP.value_low_word;
	sequence s_take; take; endsequence
	sequence s_busy; !O_REQ_READY [*2] ##1 O_REQ_READY; endsequence
	property p_lat; s_take |-> ##2 O_RSP_VALID; endproperty
	a_lat: assert property (p_lat) else $error("late response");
	property p_busy; s_take |=> s_busy; endproperty
	a_busy: assert property (p_busy) else $error("ready wrong");
	property p_cause; O_RSP_VALID |-> $past(take, 2); endproperty
	a_cause: assert property (p_cause) else $error("stray response");
	property p_hold; !O_RSP_VALID |-> $stable(O_RSP); endproperty
	a_hold: assert property (p_hold) else $error("response moved");
	property p_echo; s_take |-> ##2 O_RSP.index_word == $past(idx, 2)
		&& O_RSP.param_id_word[11:0] == $past(num, 2); endproperty
	a_echo: assert property (p_echo) else $error("layout lost");
	property p_code; take && !(code inside {4'h0, 4'h6, 4'h7})
		|-> ##2 err && eno == PCC_ERR_NO_REQ; endproperty
	a_code: assert property (p_code) else $error("bad code taken");
	property p_ehi; err |-> O_RSP.value_high_word == 16'h0000; endproperty
	a_ehi: assert property (p_ehi) else $error("error word 3");
	property p_page; take && code == 4'h6 && !(idx[7:0] inside {8'h00, 8'h90})
		|-> ##2 err && eno == PCC_ERR_NO_PARAM; endproperty
	a_page: assert property (p_page) else $error("bad page taken");
endmodule
bind pcc_top pcc_props u_props
(
	.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID),
	.I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID),
	.O_RSP(O_RSP), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
	.I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
	.O_MAP_LOCKED(O_MAP_LOCKED), .O_CONN_VALID(O_CONN_VALID),
	.O_CONN_NUMBER(O_CONN_NUMBER), .O_CONN_INDEX(O_CONN_INDEX)
);
`default_nettype wire

// file: sim/pcc_tb_top.sv
// self-checking bench of the parameter channel codec
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("wrong value t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module pcc_tb_top;
	import pcc_pkg::*;
	logic        clk, rst, go, valid, ready, rsp_valid, wr, rd, cv;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, cnum;
	logic [9:0]  cidx;
	logic [7:0]  locked;
	pcc_chan_t   req_in, req, rsp;
	int          err_total = 0;
	int          n_tests = 0;
	int          n_rsp = 0;
	int          n_got = 0;
	// responses are counted as they pulse, so a check never misses one
	always @(posedge clk)
		if (rsp_valid === 1'b1)
			n_rsp <= n_rsp + 1;
	pcc_master u_master
	(
		.i_clk(clk), .i_rst(rst), .i_go(go), .i_req(req_in),
		.i_ready(ready), .o_valid(valid), .o_req(req)
	);
	pcc_top u_dut
	(
		.I_CLK_SYS(clk), .I_RST(rst), .I_REQ_VALID(valid), .I_REQ(req),
		.O_REQ_READY(ready), .O_RSP_VALID(rsp_valid), .O_RSP(rsp),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
		.I_REG_RD(rd), .O_REG_RDATA(rdata), .O_MAP_LOCKED(locked),
		.O_CONN_VALID(cv), .O_CONN_NUMBER(cnum), .O_CONN_INDEX(cidx)
	);
	function automatic pcc_chan_t mk(logic [3:0] c, logic [10:0] n,
		logic [7:0] s, logic [7:0] p, logic [31:0] v);
		return {c, 1'b0, n, s, p, v};
	endfunction
	function automatic pcc_chan_t ans(pcc_chan_t r, logic [3:0] c,
		logic [31:0] v);
		return {c, r.param_id_word[11:0], r.index_word, v};
	endfunction
	task automatic issue(input pcc_chan_t r);
		@(posedge clk);
		go     <= 1'b1;
		req_in <= r;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic wait_rsp(input pcc_chan_t e);
		int n;
		n = 0;
		while (n_rsp <= n_got && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n_got++;
		`CHK(rsp, e)
	endtask
	task automatic xerr(input logic [3:0] c, input logic [7:0] p,
		input logic [15:0] e);
		pcc_chan_t r;
		r = mk(c, 11'd1841, 8'h02, p, 32'h0000_0000);
		issue(r);
		wait_rsp(ans(r, PCC_RSP_ERROR, {16'h0000, e}));
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	//--------------------------------
	// scenarios
	//--------------------------------
	task automatic t_reset();
		`CHK(locked, 8'hFF)
		wreg(4'hA, PCC_TEL_FREE);
		rreg(PCC_ADDR_TEL, PCC_TEL_RESET);
		rreg(PCC_ADDR_MAPLOCK, 16'hFF02);
		rreg(4'hA, 16'h0000);
	endtask
	task automatic t_store();
		pcc_chan_t w, r;
		w = mk(4'h7, 11'd3, 8'd2, PCC_PAGE_6000, 32'h1234_5678);
		r = mk(4'h6, 11'd4, 8'd1, PCC_PAGE_0, 32'h0000_0000);
		// back to back: the read waits while the write is served
		issue(w);
		issue(r);
		wait_rsp(ans(w, PCC_RSP_WORD, 32'h1234_5678));
		wait_rsp(ans(r, PCC_RSP_WORD, 32'h1234_5678));
		w = mk(4'h7, 11'd1, 8'd0, PCC_PAGE_0, 32'h0000_001A);
		issue(w);
		wait_rsp(ans(w, PCC_RSP_WORD, 32'h0000_001A));
	endtask
	task automatic t_errors();
		xerr(4'h6, PCC_PAGE_6000, PCC_ERR_NO_PARAM);
		xerr(4'h1, PCC_PAGE_0, PCC_ERR_NO_REQ);
		xerr(4'h6, 8'h80, PCC_ERR_NO_PARAM);
		rreg(PCC_ADDR_STATUS, 16'h0306);
	endtask
	task automatic t_conn();
		pcc_chan_t w;
		w = mk(4'h7, 11'd4, 8'd0, PCC_PAGE_0, {16'h02D2, 6'h3F, 10'h002});
		issue(w);
		wait_rsp(ans(w, PCC_RSP_WORD, w[31:0]));
		@(posedge clk);
		#1;
		`CHK({cv, cnum, cidx}, {1'b1, 16'h02D2, 10'h002})
	endtask
	task automatic t_tel();
		wreg(PCC_ADDR_TEL_EXT, PCC_TEL_FREE);
		`CHK(locked, 8'hFF)
		wreg(PCC_ADDR_MAPLOCK, 16'h0003);
		wreg(PCC_ADDR_TEL_EXT, 16'h0002);
		wreg(PCC_ADDR_TEL, PCC_TEL_FREE);
		`CHK(locked, 8'h07)
		wreg(PCC_ADDR_TEL_EXT, PCC_TEL_FREE);
		`CHK(locked, 8'h00)
		rreg(PCC_ADDR_TEL_EXT, PCC_TEL_FREE);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		{rst, go, wr, rd, addr, wdata, req_in} = {1'b1, 87'h0};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_store();
		t_errors();
		t_conn();
		t_tel();
		print_verdict();
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire

// file: verilog/pcc_decode.sv
// request word decoder: fields and full parameter number
`timescale 1ns/1ps
`default_nettype none
module pcc_decode
(
	input  wire pcc_pkg::pcc_chan_t i_req,
	output logic [3:0]              o_code,
	output logic [15:0]             o_full_num,
	output logic [7:0]              o_sub,
	output logic                    o_page_ok
);
	import pcc_pkg::*;

	wire [10:0] param_number_field  = i_req.param_id_word[PCC_PNU_MSB:0];
	wire [7:0]  page = i_req.index_word[PCC_PAGE_MSB:0];
	wire        pg0  = (page == PCC_PAGE_0);
	wire        pg90 = (page == PCC_PAGE_6000);

	assign o_code     = i_req.param_id_word[15:PCC_CODE_LSB];
	assign o_sub      = i_req.index_word[15:PCC_SUB_LSB];
	assign o_page_ok  = pg0 | pg90;
	// full number is the sent number plus the page offset
	assign o_full_num = {5'h00, param_number_field} + (pg90 ? PCC_OFS_6000 : 16'h0000);
endmodule
`default_nettype wire

// file: verilog/pcc_map.sv
// telegram mapping lock per process-data word
`timescale 1ns/1ps
`default_nettype none
module pcc_map
(
	input  wire logic [15:0] i_tel_sel,
	input  wire logic [15:0] i_tel_ext,
	input  wire logic [3:0]  i_std_words,
	output logic [7:0]       o_locked
);
	import pcc_pkg::*;

	wire sel_free = (i_tel_sel == PCC_TEL_FREE);
	wire ext_free = (i_tel_ext == PCC_TEL_FREE);

	genvar g;
	generate
		for (g = 0; g < PCC_MAP_WORDS; g = g + 1)
		begin : gen_lock
			// standard telegram: all locked; free telegram: words below i_std_words, none if the extension is free too
			assign o_locked[g] = !sel_free ? 1'b1 :
				(!ext_free && (g < i_std_words));
		end
	endgenerate
endmodule
`default_nettype wire

// file: verilog/pcc_top.sv
// parameter channel codec: request interpreter, parameter store, telegram map
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pcc_top
(
	input  wire logic               I_CLK_SYS,
	input  wire logic               I_RST,
	input  wire logic               I_REQ_VALID,
	input  wire pcc_pkg::pcc_chan_t I_REQ,
	output logic                    O_REQ_READY,
	output logic                    O_RSP_VALID,
	output pcc_pkg::pcc_chan_t      O_RSP,
	input  wire logic [3:0]         I_REG_ADDR,
	input  wire logic [15:0]        I_REG_WDATA,
	input  wire logic               I_REG_WR,
	input  wire logic               I_REG_RD,
	output logic [15:0]             O_REG_RDATA,
	output logic [7:0]              O_MAP_LOCKED,
	output logic                    O_CONN_VALID,
	output logic [15:0]             O_CONN_NUMBER,
	output logic [9:0]              O_CONN_INDEX
);
	import pcc_pkg::*;

	// ------------------------------------------------------------
	// request capture
	// ------------------------------------------------------------
	pcc_state_t st_q;
	pcc_state_t st_d;
	pcc_chan_t  req_q;
	pcc_chan_t  rsp_q;
	pcc_chan_t  rsp_d;
	logic [31:0] store_q [PCC_STORE_DEPTH];
	logic [15:0] tel_q;
	logic [15:0] tel_ext_q;
	logic [3:0]  std_words_q;
	logic [15:0] rdata_q;
	logic        conn_q;
	logic [15:0] conn_num_q;
	logic [9:0]  conn_idx_q;
	logic [7:0]  rsp_count_q;
	logic [7:0]  err_count_q;

	wire [3:0]  code;
	wire [15:0] full_num;
	wire [7:0]  sub;
	wire        page_ok;

	pcc_decode u_decode
	(
		.i_req      (req_q),
		.o_code     (code),
		.o_full_num (full_num),
		.o_sub      (sub),
		.o_page_ok  (page_ok)
	);

	// only one request in flight: ready only while idle
	assign O_REQ_READY = (st_q == PCC_ST_IDLE);
	wire take = I_REQ_VALID && O_REQ_READY;

	// ------------------------------------------------------------
	// parameter lookup
	// ------------------------------------------------------------
	// the store covers one window of indexed parameters; the subindex
	// selects the element, and a number outside the window is unknown
	wire [15:0] base_sel = (req_q.index_word[PCC_PAGE_MSB:0] == PCC_PAGE_6000)
		? PCC_OFS_6000 : PCC_STORE_BASE0;
	wire [15:0] rel_num  = full_num - base_sel;
	wire [15:0] elem     = rel_num + {8'h00, sub};
	wire        num_hit  = page_ok && (rel_num < 16'(PCC_STORE_DEPTH))
		&& (elem < 16'(PCC_STORE_DEPTH));
	wire [PCC_STORE_AW-1:0] addr = elem[PCC_STORE_AW-1:0];
	wire [31:0] rd_val  = store_q[addr];

	wire is_read  = (code == PCC_REQ_READ_ARR);
	wire is_write = (code == PCC_REQ_WRITE_ARR);
	wire known    = is_read || is_write;
	wire ok       = known && num_hit;
	// word 3 high half, word 4 low half; a write stores words 3 and 4 as sent
	wire [31:0] wr_val = {req_q.value_high_word, req_q.value_low_word};
	wire do_write = (st_q == PCC_ST_EXEC) && is_write && num_hit;

	// a word 4 whose top bits carry the drive object marks a connector
	wire is_conn = (req_q.value_low_word[15:PCC_DO_LSB] == PCC_DRIVE_OBJ);

	// ------------------------------------------------------------
	// response build
	// ------------------------------------------------------------
	always_comb
	begin
		rsp_d = rsp_q;
		if (st_q == PCC_ST_EXEC)
		begin
			// answer in the request layout, number and index echoed
			rsp_d.index_word    = req_q.index_word;
			if (!ok)
			begin
				rsp_d.param_id_word = {PCC_RSP_ERROR,
					req_q.param_id_word[11:0]};
				rsp_d.value_high_word = 16'h0000;
				// error number sits in the least significant value word
				rsp_d.value_low_word  = known ? PCC_ERR_NO_PARAM
					: PCC_ERR_NO_REQ;
			end
			else
			begin
				rsp_d.param_id_word = {PCC_RSP_WORD,
					req_q.param_id_word[11:0]};
				rsp_d.value_high_word = is_read ? rd_val[31:16]
					: req_q.value_high_word;
				rsp_d.value_low_word  = is_read ? rd_val[15:0]
					: req_q.value_low_word;
			end
		end
	end

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			PCC_ST_IDLE: if (take) st_d = PCC_ST_EXEC;
			PCC_ST_EXEC: st_d = PCC_ST_RESP;
			PCC_ST_RESP: st_d = PCC_ST_IDLE;
			default:     st_d = PCC_ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			st_q  <= PCC_ST_IDLE;
			req_q <= '0;
			rsp_q <= '0;
		end
		else
		begin
			st_q  <= st_d;
			rsp_q <= rsp_d;
			// read requests never look at words 3 and 4
			if (take)
				req_q <= I_REQ;
		end
	end

	assign O_RSP_VALID = (st_q == PCC_ST_RESP);
	assign O_RSP       = rsp_q;

	// ------------------------------------------------------------
	// parameter store
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < PCC_STORE_DEPTH; g = g + 1)
		begin : gen_store
			always_ff @(posedge I_CLK_SYS or posedge I_RST)
			begin
				if (I_RST)
					store_q[g] <= PCC_STORE_RESET;
				else if (do_write && (addr == PCC_STORE_AW'(g)))
					store_q[g] <= wr_val;
			end
		end
	endgenerate

	// last connector reference written, split into number and index
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			conn_q     <= 1'b0;
			conn_num_q <= 16'h0000;
			conn_idx_q <= 10'h000;
		end
		else if (do_write && is_conn)
		begin
			conn_q     <= 1'b1;
			conn_num_q <= req_q.value_high_word;
			conn_idx_q <= req_q.value_low_word[PCC_CIDX_MSB:0];
		end
	end

	assign O_CONN_VALID  = conn_q;
	assign O_CONN_NUMBER = conn_num_q;
	assign O_CONN_INDEX  = conn_idx_q;

	// ------------------------------------------------------------
	// telegram selection registers
	// ------------------------------------------------------------
	wire wr_tel     = I_REG_WR && (I_REG_ADDR == PCC_ADDR_TEL);
	wire wr_tel_ext = I_REG_WR && (I_REG_ADDR == PCC_ADDR_TEL_EXT);
	wire wr_std     = I_REG_WR && (I_REG_ADDR == PCC_ADDR_MAPLOCK);

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			tel_q       <= PCC_TEL_RESET;
			tel_ext_q   <= PCC_TEL_RESET;
			std_words_q <= PCC_LOCKED_RESET;
		end
		else
		begin
			if (wr_tel)
				tel_q <= I_REG_WDATA;
			if (wr_tel_ext)
				tel_ext_q <= I_REG_WDATA;
			if (wr_std)
				std_words_q <= I_REG_WDATA[3:0];
		end
	end

	pcc_map u_map
	(
		.i_tel_sel   (tel_q),
		.i_tel_ext   (tel_ext_q),
		.i_std_words (std_words_q),
		.o_locked    (O_MAP_LOCKED)
	);

	// ------------------------------------------------------------
	// counters and read port
	// ------------------------------------------------------------
	// counters wrap; they are diagnostics, not flow control
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			rsp_count_q <= 8'h00;
			err_count_q <= 8'h00;
		end
		else if (st_q == PCC_ST_EXEC)
		begin
			rsp_count_q <= rsp_count_q + 8'h01;
			if (!ok)
				err_count_q <= err_count_q + 8'h01;
		end
	end

	wire [15:0] status_word = {err_count_q, rsp_count_q};
	wire [15:0] rd_mux =
		(I_REG_ADDR == PCC_ADDR_TEL)     ? tel_q :
		(I_REG_ADDR == PCC_ADDR_TEL_EXT) ? tel_ext_q :
		(I_REG_ADDR == PCC_ADDR_STATUS)  ? status_word :
		(I_REG_ADDR == PCC_ADDR_MAPLOCK) ? {O_MAP_LOCKED, 4'h0, std_words_q} :
		16'h0000;

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			rdata_q <= 16'h0000;
		else if (I_REG_RD)
			rdata_q <= rd_mux;
		else
			rdata_q <= 16'h0000;
	end

	assign O_REG_RDATA = rdata_q;
endmodule
`default_nettype wire
